// ### pll_clock_control_zero_regs.vh
/*
 * register offset, field positions, reset value and decoded codes for the
 * pll clock control zero register.
 * assumes: included by the clock control block, 8-bit register file.
 */
`ifndef PLL_CLOCK_CONTROL_ZERO_REGS_VH
`define PLL_CLOCK_CONTROL_ZERO_REGS_VH

`define PCC0_ADDR 8'h00
`define PCC1_ADDR 8'h01
`define PCC0_RESET 8'h00
`define PCC0_PLLREF_HI 7
`define PCC0_PLLREF_LO 6
`define PCC0_XTAL_HI 5
`define PCC0_XTAL_LO 4
`define PCC0_SWRST_BIT 3
`define PCC0_RATIO_HI 2
`define PCC0_RATIO_LO 1
`define PCC0_POWER_UP_BIT 0
`define PLLREF_MCLK 2'h0
`define PLLREF_FRAME 2'h1
`define XTAL_ON 2'h0
`define XTAL_OFF 2'h3
`define RATIO_256 10'h100
`define RATIO_384 10'h180
`define RATIO_512 10'h200
`define RATIO_768 10'h300

`endif

// ### pll_clock_power_control_zero.v
/*
 * pll clock control zero register and its decoded clocking / power controls.
 * assumes: a serial control port (outside) presents byte writes and reads on
 * MCLK_I; it is the only writer and keeps running through software reset.
 */
// How it works
// - reference field 00 picks master clock/crystal, 01 frame clock; others reserved.
// - crystal field 00 runs oscillator, 11 turns crystal output pin off.
// - soft reset bit 1 holds all but control port in reset; 0 releases.
// - soft reset restores other registers, never registers 0x00 and 0x01.
// - ratio field codes 00..11 select 256, 384, 512, 768 times sample rate.
// - bit 0 low means master power-down, high means powered up.
// - register 0x00 resets to all zeros.
`include "pll_clock_control_zero_regs.vh"
module pll_clock_power_control_zero (
    input wire MCLK_I,
    input wire ARST_N_I,
    input wire WR_EN_I,
    input wire [7:0] WR_ADDR_I,
    input wire [7:0] WR_DATA_I,
    input wire [7:0] RD_ADDR_I,
    output reg [7:0] RD_DATA_O,
    output reg PLL_REF_FRAME_SEL_O,
    output reg PLL_REF_RESERVED_O,
    output reg CRYSTAL_OUT_EN_O,
    output reg CRYSTAL_SET_RESERVED_O,
    output reg [9:0] MCLK_RATIO_O,
    output reg CORE_RESET_N_O,
    output reg OTHER_REGS_RESET_O,
    output reg POWER_UP_O
);

reg [7:0] pll_clock_control_zero_reg;
reg [7:0] pll_clock_control_zero_next;
reg [7:0] rd_data_next;
reg pll_ref_frame_sel_next;
reg pll_ref_reserved_next;
reg crystal_out_en_next;
reg crystal_set_reserved_next;
reg [9:0] mclk_ratio_next;
reg core_reset_n_next;
reg other_regs_reset_next;
reg power_up_next;
wire wr_hit;
wire [1:0] pll_reference_select;
wire [1:0] crystal_osc_setting;
wire soft_reset_bit;
wire [1:0] master_clock_ratio_select;
wire master_power_up;

function [9:0] ratio_decode;
    input [1:0] code;
    begin
        case (code)
            2'h0: ratio_decode = `RATIO_256;
            2'h1: ratio_decode = `RATIO_384;
            2'h2: ratio_decode = `RATIO_512;
            default: ratio_decode = `RATIO_768;
        endcase
    end
endfunction

// reserved codes are stored as written and only flagged, never rewritten
function pll_ref_is_reserved;
    input [1:0] code;
    begin
        case (code)
            `PLLREF_MCLK: pll_ref_is_reserved = 1'b0;
            `PLLREF_FRAME: pll_ref_is_reserved = 1'b0;
            default: pll_ref_is_reserved = 1'b1;
        endcase
    end
endfunction

function crystal_is_reserved;
    input [1:0] code;
    begin
        case (code)
            `XTAL_ON: crystal_is_reserved = 1'b0;
            `XTAL_OFF: crystal_is_reserved = 1'b0;
            default: crystal_is_reserved = 1'b1;
        endcase
    end
endfunction

// any other address reads zero, so the host never sees a stale byte
function [7:0] read_select;
    input [7:0] addr;
    input [7:0] value;
    begin
        if (addr == `PCC0_ADDR) begin
            read_select = value;
        end else begin
            read_select = 8'h00;
        end
    end
endfunction

assign wr_hit = WR_EN_I && (WR_ADDR_I == `PCC0_ADDR);
assign pll_reference_select = pll_clock_control_zero_reg[`PCC0_PLLREF_HI:`PCC0_PLLREF_LO];
assign crystal_osc_setting = pll_clock_control_zero_reg[`PCC0_XTAL_HI:`PCC0_XTAL_LO];
assign soft_reset_bit = pll_clock_control_zero_reg[`PCC0_SWRST_BIT];
assign master_clock_ratio_select = pll_clock_control_zero_reg[`PCC0_RATIO_HI:`PCC0_RATIO_LO];
assign master_power_up = pll_clock_control_zero_reg[`PCC0_POWER_UP_BIT];

// writes to other addresses leave the register untouched
always @* begin
    pll_clock_control_zero_next = pll_clock_control_zero_reg;
    if (wr_hit) begin
        pll_clock_control_zero_next = WR_DATA_I;
    end
end

always @* begin
    pll_ref_frame_sel_next = (pll_reference_select == `PLLREF_FRAME);
end

always @* begin
    pll_ref_reserved_next = pll_ref_is_reserved(pll_reference_select);
end

// reserved crystal codes leave the oscillator running, the safer choice
always @* begin
    crystal_out_en_next = (crystal_osc_setting != `XTAL_OFF);
end

always @* begin
    crystal_set_reserved_next = crystal_is_reserved(crystal_osc_setting);
end

always @* begin
    mclk_ratio_next = ratio_decode(master_clock_ratio_select);
end

always @* begin
    core_reset_n_next = ~soft_reset_bit;
end

always @* begin
    other_regs_reset_next = soft_reset_bit;
end

always @* begin
    power_up_next = master_power_up;
end

always @* begin
    rd_data_next = read_select(RD_ADDR_I, pll_clock_control_zero_reg);
end

// register lives in the control-port domain so soft reset never clears it
always @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
        pll_clock_control_zero_reg <= `PCC0_RESET;
    end else begin
        pll_clock_control_zero_reg <= pll_clock_control_zero_next;
    end
end

always @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
        RD_DATA_O <= 8'h00;
    end else begin
        RD_DATA_O <= rd_data_next;
    end
end

// decoded controls come from flops so the core never sees decode glitches
always @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
        PLL_REF_FRAME_SEL_O <= 1'b0;
    end else begin
        PLL_REF_FRAME_SEL_O <= pll_ref_frame_sel_next;
    end
end

always @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
        PLL_REF_RESERVED_O <= 1'b0;
    end else begin
        PLL_REF_RESERVED_O <= pll_ref_reserved_next;
    end
end

// oscillator runs from reset, matching the all-zero register
always @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
        CRYSTAL_OUT_EN_O <= 1'b1;
    end else begin
        CRYSTAL_OUT_EN_O <= crystal_out_en_next;
    end
end

always @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
        CRYSTAL_SET_RESERVED_O <= 1'b0;
    end else begin
        CRYSTAL_SET_RESERVED_O <= crystal_set_reserved_next;
    end
end

always @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
        MCLK_RATIO_O <= `RATIO_256;
    end else begin
        MCLK_RATIO_O <= mclk_ratio_next;
    end
end

// core stays held while the pin reset is low, released one edge later
always @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
        CORE_RESET_N_O <= 1'b0;
    end else begin
        CORE_RESET_N_O <= core_reset_n_next;
    end
end

always @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
        OTHER_REGS_RESET_O <= 1'b1;
    end else begin
        OTHER_REGS_RESET_O <= other_regs_reset_next;
    end
end

always @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
        POWER_UP_O <= 1'b0;
    end else begin
        POWER_UP_O <= power_up_next;
    end
end

endmodule // pll_clock_power_control_zero

// ### pcc0_props.sv
/* checker for the clock control zero register. assumes: bound onto the top module */
module pcc0_props(input wire MCLK_I, ARST_N_I, WR_EN_I,
    input wire [7:0] WR_ADDR_I, WR_DATA_I, RD_ADDR_I, RD_DATA_O,
    input wire PLL_REF_FRAME_SEL_O, PLL_REF_RESERVED_O, CRYSTAL_OUT_EN_O,
    input wire CRYSTAL_SET_RESERVED_O, CORE_RESET_N_O, OTHER_REGS_RESET_O, POWER_UP_O,
    input wire [9:0] MCLK_RATIO_O);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] s, q;
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!ARST_N_I);
    sequence rd0; RD_ADDR_I == 8'h00; endsequence
    always @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            s <= 8'h00;
            q <= 8'h00;
        end else begin
            if (WR_EN_I && WR_ADDR_I == 8'h00) s <= WR_DATA_I;
            q <= s;
        end
    end
    pwr_up_a: assert property (POWER_UP_O == q[0]) else $error("power up");
    ref_sel_a: assert property (PLL_REF_FRAME_SEL_O == (q[7:6] == 2'h1)) else $error("ref");
    xtal_en_a: assert property (CRYSTAL_OUT_EN_O == (q[5:4] != 2'h3)) else $error("xtal");
    ref_rsv_a: assert property (PLL_REF_RESERVED_O == q[7]) else $error("ref reserved");
    xtal_rsv_a: assert property (CRYSTAL_SET_RESERVED_O == (q[5] != q[4]))
        else $error("xtal reserved");
    soft_rst_a: assert property ($past(ARST_N_I) |-> CORE_RESET_N_O == !q[3]
        && OTHER_REGS_RESET_O == q[3]) else $error("soft reset");
    ratio_sel_a: assert property (MCLK_RATIO_O == (q[2:1] == 2'h3 ? 10'h300
        : 10'h100 + {q[2:1], 7'h00})) else $error("ratio");
    rd_back_a: assert property (rd0 |=> RD_DATA_O == $past(s)) else $error("read");
    rst_zero_a: assert property ($rose(ARST_N_I) |=> RD_DATA_O == 8'h00
        && !POWER_UP_O) else $error("reset");
endmodule // pcc0_props
bind pll_clock_power_control_zero pcc0_props chk(.*);

// ### host_model.sv
/* host writing over the control port. assumes: one write strobe per byte */
module host_model(input wire clk_i, output logic we_o, output logic [7:0] wa_o, wd_o);
    timeunit 1ns; timeprecision 1ns;
    initial {we_o, wa_o, wd_o} = 17'h0;
    task wr(input [7:0] a, d);
        @(posedge clk_i); #1 {we_o, wa_o, wd_o} <= {1'b1, a, d};
        @(posedge clk_i); #1 {we_o, wa_o, wd_o} <= {1'b0, ~a, ~d}; // released lines carry the inverted address and data
    endtask
endmodule // host_model

// ### tb_pll_clock_power_control_zero.sv
/* bench for the clock control zero register. assumes: host_model and checker present */
module tb_pll_clock_power_control_zero;
    timeunit 1ns; timeprecision 1ns;
    logic clk = 0, rst_n = 0, we;
    logic [7:0] wa, wd, ra = 8'h00;
    wire [7:0] rd;
    wire fs, fr, xe, xr, cr, orr, pu;
    wire [9:0] rt;
    int bad_count = 0, n_checks = 0;
    logic [9:0] r[4] = '{10'h100, 10'h180, 10'h200, 10'h300};
    initial forever #50 clk = ~clk;
    host_model host(.clk_i(clk), .we_o(we), .wa_o(wa), .wd_o(wd));
    pll_clock_power_control_zero uut(.MCLK_I(clk), .ARST_N_I(rst_n), .WR_EN_I(we),
        .WR_ADDR_I(wa), .WR_DATA_I(wd), .RD_ADDR_I(ra), .RD_DATA_O(rd),
        .PLL_REF_FRAME_SEL_O(fs), .PLL_REF_RESERVED_O(fr), .CRYSTAL_OUT_EN_O(xe),
        .CRYSTAL_SET_RESERVED_O(xr), .MCLK_RATIO_O(rt), .CORE_RESET_N_O(cr),
        .OTHER_REGS_RESET_O(orr), .POWER_UP_O(pu));
    task chk(input [19:0] g, e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: %h not %h", $time, g, e);
        end
    endtask
    task rdr(input [7:0] a, e);
        @(posedge clk); #1 ra = a;
        @(posedge clk); #1 chk(rd, e);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1 rst_n = 1;
        rdr(8'h00, 8'h00);
        chk({fs, fr, xe, xr, rt, cr, orr, pu}, {4'b0010, 10'h100, 3'b100});
        host.wr(8'h00, 8'h01);
        rdr(8'h00, 8'h01);
        chk(pu, 1'b1);
        for (int i = 0; i < 4; i++) begin
            host.wr(8'h00, {i[1:0], i[1:0], 1'b0, i[1:0], 1'b1});
            @(posedge clk); #1 chk({fs, fr, xe, xr, rt}, {i == 1, i[1], i != 3, i[1] ^ i[0], r[i]});
        end
        host.wr(8'h00, 8'h09);
        host.wr(8'h01, 8'h00);
        chk({cr, orr, pu}, 3'b011);
        rdr(8'h00, 8'h09);
        rdr(8'h01, 8'h00);
        host.wr(8'h00, 8'h01);
        @(posedge clk); #1 chk({cr, orr}, 2'b10);
        rst_n = 0;
        @(posedge clk); #1 rst_n = 1;
        rdr(8'h00, 8'h00);
        chk({cr, orr, pu}, 3'b100);
        finish_test;
    end
endmodule // tb_pll_clock_power_control_zero
